// ==== rtl/bads_core.sv ====
// four-phase execution slice: decimal adjust, decrement file, compare-and-skip
// Overview of operation
// RULE1: low nibble plus 6 when above 9 or digit carry set
// RULE2: high nibble plus 6 when above 9 or carry set
// RULE3: decimal adjust takes one cycle: decode, read, process, write
// RULE4: skip over a two-word instruction costs two all-nop cycles
// RULE5: greater-than compare skips next instruction when file exceeds working register
// RULE6: decrement takes 8-bit address, destination bit and access bank bit
// RULE7: decimal adjust changes only carry, set by carry out of bit 7
`timescale 1ns/1ps
module bads_core (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  instrValid,
   input  wire bads_pkg::bads_instr_t instr,
   input  wire logic [7:0]            fileData,
   output logic                       instrReady,
   output logic [7:0]                 workingReg,
   output bads_pkg::bads_flags_t      flags,
   output logic [7:0]                 fileAddrOut,
   output logic                       accessSelOut,
   output logic                       fileWrEn,
   output logic [7:0]                 fileWrData,
   output logic                       skipNext,
   output logic                       nopCycle,
   output bads_pkg::bads_phase_t      phase
);
   import bads_pkg::*;

   // refuse package settings that the phase ring, the datapath or the skip counter cannot serve
   if (PHASES != 4) begin : g_phaseChk
      $error("phase ring is built for four phases only");
   end
   if (DATA_W != 8) begin : g_widthChk
      $error("datapath is built for eight bits only");
   end
   if (SKIP_CYC_TWO <= SKIP_CYC_ONE) begin : g_skipChk
      $error("two-word skip must discard more cycles than a one-word skip");
   end

   // compare ops are decoded both in process and in skip control
   function automatic logic isCompare(input bads_op_t op);
      return (op == BADS_OP_CPGT) || (op == BADS_OP_CPLT);
   endfunction

   // RULE5: outcome of the compare ops, file register against working register
   function automatic logic compareHit(input bads_op_t op, input logic [7:0] f, input logic [7:0] w);
      unique case (op)
         BADS_OP_CPGT: return f > w;
         BADS_OP_CPLT: return f < w;
         default:      return 1'b0;
      endcase
   endfunction

   // nop cycles to discard after a taken skip
   function automatic logic [1:0] skipCycles(input logic twoWord);
      return twoWord ? SKIP_CYC_TWO : SKIP_CYC_ONE;
   endfunction

   // destination 0 of a decrement is the working register, 1 the file register
   function automatic logic writesWork(input bads_instr_t ins);
      return (ins.op == BADS_OP_DECADJ) || (ins.op == BADS_OP_DEC && !ins.destSel);
   endfunction

   bads_phase_t phase_q;
   bads_phase_t phase_d;
   bads_instr_t cur_q;
   logic [7:0]  work_q;
   logic [7:0]  operand_q;
   logic [7:0]  result_q;
   logic        carry_q;
   logic        dcarry_q;
   logic        skipDec_q;
   logic [1:0]  nopLeft_q;
   logic        busy_q;
   logic        skipNext_q;
   logic        wrEn_q;
   logic [7:0]  wrData_q;
   logic [7:0]  adjValue;
   logic        adjCarry;

   bads_decimal_adjust uAdj (
      .valueIn      (operand_q),
      .carryIn      (carry_q),
      .digitCarryIn (dcarry_q),
      .valueOut     (adjValue),
      .carryOut     (adjCarry)
   );

   // new instruction only at Q1 of a cycle that is not a nop cycle
   assign instrReady = (phase_q == BADS_Q1) && (nopLeft_q == 2'h0);

   // next phase of the ring; an illegal code falls back to Q1 so the ring recovers
   always_comb begin
      unique case (phase_q)
         BADS_Q1: phase_d = BADS_Q2;
         BADS_Q2: phase_d = BADS_Q3;
         BADS_Q3: phase_d = BADS_Q4;
         BADS_Q4: phase_d = BADS_Q1;
         default: phase_d = BADS_Q1;
      endcase
   end

   // phase ring, one instruction cycle per four clocks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_q <= BADS_Q1;
      end else begin
         phase_q <= phase_d;
      end
   end

   // RULE3: decode in Q1
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cur_q  <= '0;
         busy_q <= 1'b0;
      end else if (phase_q == BADS_Q1) begin
         busy_q <= instrReady && instrValid;
         // RULE6: latch address, destination and bank select
         cur_q  <= (instrReady && instrValid) ? instr : '0;
      end
   end

   // RULE3: read operand in Q2
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         operand_q <= WORK_RST;
      end else if (phase_q == BADS_Q2 && busy_q) begin
         operand_q <= (cur_q.op == BADS_OP_DECADJ) ? work_q : fileData;
      end
   end

   // RULE3: process in Q3
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         result_q  <= WORK_RST;
         skipDec_q <= 1'b0;
      end else if (phase_q == BADS_Q3) begin
         skipDec_q <= 1'b0;
         if (busy_q) begin
            unique case (cur_q.op)
               // RULE1: adjusted value from the bcd corrector
               BADS_OP_DECADJ: result_q <= adjValue;
               BADS_OP_DEC:    result_q <= operand_q - 8'h01;
               // RULE5: CPGT skips when file register exceeds working register, CPLT when it is below it
               BADS_OP_CPGT,
               BADS_OP_CPLT:   skipDec_q <= compareHit(cur_q.op, operand_q, work_q);
               default:        result_q <= result_q;
            endcase
         end
      end
   end

   // RULE3: write back in Q4
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         work_q <= WORK_RST;
      end else if (phase_q == BADS_Q4 && busy_q && writesWork(cur_q)) begin
         work_q <= result_q;
      end
   end

   // RULE7: only the carry is touched, and only by decimal adjust
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         carry_q <= 1'b0;
      end else if (phase_q == BADS_Q4 && busy_q && cur_q.op == BADS_OP_DECADJ) begin
         carry_q <= adjCarry;
      end
   end

   // digit carry is read by the adjust but never written, it keeps its reset value 0
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dcarry_q <= 1'b0;
      end else begin
         dcarry_q <= dcarry_q;
      end
   end

   // destination 1 sends the decrement back to the file register as a one-clock strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrEn_q   <= 1'b0;
         wrData_q <= 8'h00;
      end else begin
         wrEn_q <= 1'b0;
         if (phase_q == BADS_Q4 && busy_q && cur_q.op == BADS_OP_DEC && cur_q.destSel) begin
            wrEn_q   <= 1'b1;
            wrData_q <= result_q;
         end
      end
   end

   // RULE4: skip discards one or two following cycles as nops
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         nopLeft_q  <= 2'h0;
         skipNext_q <= 1'b0;
      end else begin
         skipNext_q <= 1'b0;
         if (phase_q == BADS_Q4 && busy_q && isCompare(cur_q.op) && skipDec_q) begin
            skipNext_q <= 1'b1;
            nopLeft_q  <= skipCycles(cur_q.nextTwoWord);
         end else if (phase_q == BADS_Q4 && nopLeft_q != 2'h0) begin
            nopLeft_q <= nopLeft_q - 2'h1;
         end
      end
   end

   // adjust reads flags after Q4 update, so flags are stable during Q3 of the next op
   assign workingReg   = work_q;
   assign flags        = '{carry: carry_q, digitCarry: dcarry_q};
   assign fileAddrOut  = cur_q.fileAddr;
   assign accessSelOut = cur_q.accessSel;
   assign fileWrEn     = wrEn_q;
   assign fileWrData   = wrData_q;
   assign skipNext     = skipNext_q;
   assign nopCycle     = nopLeft_q != 2'h0;
   assign phase        = phase_q;
endmodule

// ==== rtl/bads_pkg.sv ====
// package for the bcd adjust / decrement / skip execution slice
package bads_pkg;
   localparam int          DATA_W        = 8;
   localparam int          PHASES        = 4;
   localparam logic [3:0]  NIBBLE_MAX    = 4'h9;
   localparam logic [3:0]  BCD_FIX       = 4'h6;
   localparam logic [7:0]  WORK_RST      = 8'h00;
   localparam logic [1:0]  SKIP_CYC_ONE  = 2'h1;
   localparam logic [1:0]  SKIP_CYC_TWO  = 2'h2;

   typedef enum logic [2:0] {
      BADS_OP_NONE  = 3'h0,
      BADS_OP_DECADJ = 3'h1,
      BADS_OP_DEC   = 3'h2,
      BADS_OP_CPGT  = 3'h3,
      BADS_OP_CPLT  = 3'h4
   } bads_op_t;

   typedef struct packed {
      bads_op_t   op;
      logic [7:0] fileAddr;
      logic       destSel;
      logic       accessSel;
      logic       nextTwoWord;
   } bads_instr_t;

   typedef struct packed {
      logic carry;
      logic digitCarry;
   } bads_flags_t;

   typedef enum logic [3:0] {
      BADS_Q1 = 4'b0001,
      BADS_Q2 = 4'b0010,
      BADS_Q3 = 4'b0100,
      BADS_Q4 = 4'b1000
   } bads_phase_t;
endpackage

// ==== rtl/bads_decimal_adjust.sv ====
// combinational packed-bcd correction of the working register
`timescale 1ns/1ps
module bads_decimal_adjust (
   input  wire logic [7:0] valueIn,
   input  wire logic       carryIn,
   input  wire logic       digitCarryIn,
   output logic [7:0]      valueOut,
   output logic            carryOut
);
   import bads_pkg::*;
   logic [4:0] lowSum;
   logic [4:0] highSum;
   logic       lowFix;
   logic       highFix;

   always_comb begin
      // RULE1: low nibble fix
      lowFix  = (valueIn[3:0] > NIBBLE_MAX) || digitCarryIn;
      lowSum  = {1'b0, valueIn[3:0]} + (lowFix ? {1'b0, BCD_FIX} : 5'h00);
      // RULE2: high nibble fix, low carry propagates as in an 8-bit add
      highFix = (valueIn[7:4] > NIBBLE_MAX) || carryIn;
      highSum = {1'b0, valueIn[7:4]} + (highFix ? {1'b0, BCD_FIX} : 5'h00) + {4'h0, lowSum[4]};
      valueOut = {highSum[3:0], lowSum[3:0]};
      // RULE7: carry only from bit 7, kept if already set
      carryOut = highSum[4] | carryIn;
   end
endmodule

// ==== verification/bads_core_chk.sv ====
// assertion checker for the bads core execution slice
`timescale 1ns/1ps
module bads_core_chk (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  instrValid,
   input wire bads_pkg::bads_instr_t instr,
   input wire logic [7:0]            fileData,
   input wire logic                  instrReady,
   input wire logic [7:0]            workingReg,
   input wire bads_pkg::bads_flags_t flags,
   input wire logic                  fileWrEn,
   input wire logic                  skipNext,
   input wire logic                  nopCycle,
   input wire bads_pkg::bads_phase_t phase
);
   import bads_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic [3:0] lowNib = workingReg[3:0];
   wire logic       take   = rst_n && phase == BADS_Q1 && instrReady && instrValid;
   bads_op_t        opQ;
   logic            twoQ;
   logic            hitQ;
   // op is cleared on idle slots so stale ops never arm a check
   always_ff @(posedge clk) begin
      if (!rst_n || phase == BADS_Q1) begin
         opQ  <= take ? instr.op : BADS_OP_NONE;
         twoQ <= instr.nextTwoWord;
      end
      if (phase == BADS_Q2) begin
         hitQ <= opQ == BADS_OP_CPGT ? fileData > workingReg : fileData < workingReg;
      end
   end
   property p_walk;
      phase == BADS_Q1 |=> phase == BADS_Q2 ##1 phase == BADS_Q3 ##1 phase == BADS_Q4 ##1 phase == BADS_Q1;
   endproperty
   property p_keep; $changed(workingReg) || $changed(flags) |-> phase == BADS_Q1; endproperty
   property p_ready; instrReady |-> phase == BADS_Q1 && !nopCycle; endproperty
   property p_skip4; skipNext && !twoQ |-> nopCycle [*4] ##1 !nopCycle; endproperty
   property p_skip8; skipNext && twoQ |-> nopCycle [*8] ##1 !nopCycle; endproperty
   property p_cause; skipNext |-> (opQ == BADS_OP_CPGT || opQ == BADS_OP_CPLT) && hitQ; endproperty
   property p_gt; phase == BADS_Q4 && opQ == BADS_OP_CPGT && hitQ |=> skipNext; endproperty
   property p_wr; fileWrEn |-> opQ == BADS_OP_DEC ##1 !fileWrEn; endproperty
   property p_low;
      phase == BADS_Q4 && opQ == BADS_OP_DECADJ && lowNib > 4'h9 |=> lowNib == $past(lowNib) + 4'h6;
   endproperty
   property p_high;
      phase == BADS_Q4 && opQ == BADS_OP_DECADJ && (workingReg[7:4] > 4'h9 || flags.carry) |=> flags == 2'h2;
   endproperty
   a_walk: assert property (p_walk) else $error("phase walk broken");
   a_keep: assert property (p_keep) else $error("result written off the cycle end");
   a_ready: assert property (p_ready) else $error("ready outside free Q1");
   a_skip4: assert property (p_skip4) else $error("one-word skip length");
   a_skip8: assert property (p_skip8) else $error("two-word skip length");
   a_cause: assert property (p_cause) else $error("skip without cause");
   a_gt: assert property (p_gt) else $error("greater compare did not skip");
   a_wr: assert property (p_wr) else $error("bad file write pulse");
   a_low: assert property (p_low) else $error("low nibble fix");
   a_high: assert property (p_high) else $error("high nibble carry");
   c_skip8: cover property (skipNext && twoQ);
   c_adj: cover property (phase == BADS_Q4 && opQ == BADS_OP_DECADJ);
   c_wr: cover property (fileWrEn);
endmodule

bind bads_core bads_core_chk u_chk (.clk, .rst_n, .instrValid, .instr, .fileData, .instrReady, .workingReg,
   .flags, .fileWrEn, .skipNext, .nopCycle, .phase);

// ==== verification/tb_bads_core.sv ====
// self-checking bench for the bads core execution slice
`timescale 1ns/1ps
module tb_bads_core;
   import bads_pkg::*;
   typedef struct {bads_op_t op; logic [7:0] fd; logic dest, two; logic [7:0] w; logic c, wr, sk; int nop;} bads_row_t;
   logic        clk = 0, rst_n = 0, instrValid = 0;
   bads_instr_t instr = '0;
   logic [7:0]  fileData = '0;
   wire logic   instrReady, accessSelOut, fileWrEn, skipNext, nopCycle;
   wire logic [7:0] workingReg, fileAddrOut, fileWrData;
   wire bads_flags_t flags;
   wire bads_phase_t phase;
   int          n_mismatch = 0, tests_run = 0, n;
   bads_row_t   rows[12] = '{'{BADS_OP_DECADJ,8'h00,0,0,8'h00,0,0,0,0}, '{BADS_OP_DEC,8'h1b,0,0,8'h1a,0,0,0,0},
      '{BADS_OP_DECADJ,8'h00,0,0,8'h20,0,0,0,0}, '{BADS_OP_DEC,8'ha6,0,0,8'ha5,0,0,0,0},
      '{BADS_OP_DECADJ,8'h00,0,0,8'h05,1,0,0,0}, '{BADS_OP_DEC,8'h1b,0,0,8'h1a,1,0,0,0},
      '{BADS_OP_DECADJ,8'h00,0,0,8'h80,1,0,0,0}, '{BADS_OP_DEC,8'h10,1,0,8'h80,1,1,0,0},
      '{BADS_OP_CPGT,8'h81,0,0,8'h80,1,0,1,4}, '{BADS_OP_CPGT,8'h80,0,1,8'h80,1,0,0,0},
      '{BADS_OP_CPLT,8'h7f,0,1,8'h80,1,0,1,8}, '{BADS_OP_DEC,8'h00,0,0,8'hff,1,0,0,0}};
   bads_core uut (.clk, .rst_n, .instrValid, .instr, .fileData, .instrReady, .workingReg, .flags, .fileAddrOut,
      .accessSelOut, .fileWrEn, .fileWrData, .skipNext, .nopCycle, .phase);
   initial begin
      forever #2.5 clk = ~clk;
   end
   task test_done;
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task run(input bads_row_t r);
      @(posedge clk);
      instr <= '{r.op, ~r.fd, r.dest, r.two, r.two};
      fileData <= r.fd;
      instrValid <= 1;
      // look only at settled values, never in the edge's own time step
      for (n = 0; n < 24; n++) begin
         @(negedge clk);
         if (phase === BADS_Q1 && instrReady === 1'b1) break;
      end
      if (n >= 24) begin
         n_mismatch++;
         test_done();
      end
      @(posedge clk);
      instrValid <= 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("workingReg", workingReg, r.w);
      chk("flags", 8'(flags), {6'h0, r.c, 1'b0});
      chk("skipNext", 8'(skipNext), 8'(r.sk));
      chk("fileWrEn", 8'(fileWrEn), 8'(r.wr));
      if (r.wr) chk("fileWrData", fileWrData, r.fd - 8'h01);
      if (r.op == BADS_OP_DEC) chk("fileAddrOut", fileAddrOut, ~r.fd);
      if (r.op == BADS_OP_DEC) chk("accessSelOut", 8'(accessSelOut), 8'(r.two));
      for (n = 0; nopCycle === 1'b1 && n < 12; n++) @(negedge clk);
      chk("nopCycles", 8'(n), 8'(r.nop));
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      @(negedge clk);
      foreach (rows[i]) run(rows[i]);
      // reset in mid-run clears the carry that the adjust set
      @(posedge clk);
      rst_n <= 0;
      @(posedge clk);
      rst_n <= 1;
      @(negedge clk);
      chk("resetState", {workingReg[5:0], flags}, 8'h00);
      chk("resetPhase", {3'h0, instrReady, phase}, 8'h11);
      run(rows[0]);
      test_done();
   end
endmodule
